// >>> hw/madm_cfg.svh
// constants for the madi sample mux mapper: slot counts, widths, clock figures
// assumes a single 100 MHz system clock; included by its bare name
// Notes on behaviour
// R1: in quad rate mode with 48K frames one channel fills four consecutive slots, so at most 16 channels fit.
// R2: interleaved double or quad rate audio leaves the link itself at the single speed 44.1 or 48 kHz rate.
// R3: 192 kHz audio travels only by quad sample interleave in 48K frames and there is no 192K frame format.
// R4: the clock recovery locks directly to a reference from 25 kHz to 200 kHz and follows pitch changes in phase.
// R5: the 48K frame carries up to 64 channels of at most 48 kHz each.
// R6: the 96K frame carries up to 32 channels of at most 96 kHz each.
// R7: a received 96K frame yields the double rate by itself, at once, with no setting.
// R8: with interleaved 48K frames the effective rate comes from the configured speed setting.
// R9: interleave and de-interleave only move samples between slots and never change a value.
// R10: the cleaned recovered clock drives the word clock output and times the transmit frame starts; slots move on link clock edges.
// R11: audio up to 96 kHz travels in 48K frames by dual sample interleave.
// R12: in double rate mode with 48K frames one channel fills two consecutive slots, so at most 32 channels fit.
// R13: within a group, later samples of a channel go to higher slots and are rebuilt in that order.
`ifndef MADM_CFG_SVH
`define MADM_CFG_SVH

`define MADM_DATA_W      24
`define MADM_SLOT_W      6
`define MADM_SLOTS_48K   7'h40
`define MADM_SLOTS_96K   7'h20
`define MADM_MCLK_HZ     100000000
`define MADM_REF_MIN_HZ  25000
`define MADM_REF_MAX_HZ  200000
`define MADM_INT_HZ      48000
`define MADM_PER_W       13
`define MADM_REF_MAX_CYC (`MADM_MCLK_HZ / `MADM_REF_MIN_HZ)
`define MADM_REF_MIN_CYC ((`MADM_MCLK_HZ + `MADM_REF_MAX_HZ - 1) / `MADM_REF_MAX_HZ)
`define MADM_INT_PER_CYC (`MADM_MCLK_HZ / `MADM_INT_HZ)
`define MADM_LOCK_TOL    13'h008

`endif

// >>> hw/madm_pkg.sv
// types shared by the madi sample mux mapper files
// assumes madm_cfg.svh supplies the numeric constants
package madm_pkg;
  typedef enum logic [1:0] {
    MADM_SINGLE,
    MADM_DOUBLE,
    MADM_QUAD
  } madm_speed_t;
endpackage : madm_pkg

// >>> hw/madm_sample_mux_mapper.sv
// madi sample mux mapper: channel samples to frame slots and back,
// plus reference clock recovery driving the word clock output
// assumes link and reference pins are asynchronous to mclk_i
`timescale 1ns/10ps
`default_nettype none
`include "madm_cfg.svh"
module madm_sample_mux_mapper #(
  parameter int DW = `MADM_DATA_W
) (
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  input  wire logic                  frame_96k_i,
  input  wire madm_pkg::madm_speed_t speed_mode_i,
  input  wire logic                  ref_clk_i,
  input  wire logic                  link_clk_i,
  input  wire logic                  ch_valid_i,
  input  wire logic [5:0]            ch_num_i,
  input  wire logic [1:0]            ch_phase_i,
  input  wire logic [DW-1:0]         ch_data_i,
  input  wire logic [DW-1:0]         link_rx_data_i,
  input  wire logic                  link_rx_start_i,
  input  wire logic                  link_rx_96k_i,
  output logic      [DW-1:0]         link_tx_data_o,
  output logic                       link_tx_valid_o,
  output logic                       link_tx_start_o,
  output logic                       link_tx_96k_o,
  output logic                       ch_out_valid_o,
  output logic      [5:0]            ch_out_num_o,
  output logic      [1:0]            ch_out_phase_o,
  output logic      [DW-1:0]         ch_out_data_o,
  output logic                       ch_accept_o,
  output madm_pkg::madm_speed_t      rate_o,
  output logic                       ref_lock_o,
  output logic                       word_clk_o,
  output logic                       frame_tick_o
);
  import madm_pkg::*;

  localparam logic [12:0] REF_MIN = 13'(`MADM_REF_MIN_CYC);
  localparam logic [12:0] REF_MAX = 13'(`MADM_REF_MAX_CYC);
  localparam logic [12:0] INT_PER = 13'(`MADM_INT_PER_CYC);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0]    clk_lvl;
  logic [1:0]    clk_rise;
  logic [DW+1:0] rx_lvl;
  logic          ref_rise;
  logic          link_rise;
  logic [DW-1:0] rx_data;
  logic          rx_start;
  logic          rx_96k;

  madm_sync #(.W(2)) u_clk_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i ({ref_clk_i, link_clk_i}),
    .sync_o  (clk_lvl),
    .rise_o  (clk_rise)
  );

  madm_sync #(.W(DW+2)) u_rx_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i ({link_rx_96k_i, link_rx_start_i, link_rx_data_i}),
    .sync_o  (rx_lvl),
    .rise_o  ()
  );

  assign ref_rise  = clk_rise[1];
  assign link_rise = clk_rise[0];
  assign rx_data   = rx_lvl[DW-1:0];
  assign rx_start  = rx_lvl[DW];
  assign rx_96k    = rx_lvl[DW+1];

  // ****************************************
  // clock recovery and word clock
  // ****************************************
  logic [12:0] per_cnt_reg;
  logic [12:0] per_reg;
  logic [12:0] wc_cnt_reg;
  logic        lock_reg;
  logic [12:0] per_use;
  logic        per_ok;
  logic        per_close;
  logic        wc_wrap;

  assign per_ok    = (per_cnt_reg + 13'h001 >= REF_MIN) && (per_cnt_reg + 13'h001 <= REF_MAX);
  assign per_close = (per_cnt_reg + 13'h001 >= per_reg) ? (per_cnt_reg + 13'h001 - per_reg <= `MADM_LOCK_TOL)
                                                        : (per_reg - per_cnt_reg - 13'h001 <= `MADM_LOCK_TOL);
  assign per_use   = lock_reg ? per_reg : INT_PER;
  assign wc_wrap   = (wc_cnt_reg >= per_use - 13'h001);

  // R4 period measure and lock window
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      per_cnt_reg <= 13'h000;
      per_reg     <= 13'h000;
      lock_reg    <= 1'b0;
    end else if (ref_rise) begin
      per_cnt_reg <= 13'h000;
      per_reg     <= per_cnt_reg + 13'h001;
      lock_reg    <= per_ok && per_close;
    end else if (per_cnt_reg > REF_MAX) begin
      // reference gone or below range
      lock_reg    <= 1'b0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 13'h001;
    end
  end

  // R4 phase tracking of the regenerated clock
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wc_cnt_reg <= 13'h000;
    end else if ((lock_reg && ref_rise) || wc_wrap) begin
      wc_cnt_reg <= 13'h000;
    end else begin
      wc_cnt_reg <= wc_cnt_reg + 13'h001;
    end
  end

  // R10 cleaned clock to word clock out
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      word_clk_o   <= 1'b0;
      frame_tick_o <= 1'b0;
      ref_lock_o   <= 1'b0;
    end else begin
      word_clk_o   <= (wc_cnt_reg < {1'b0, per_use[12:1]});
      frame_tick_o <= (wc_cnt_reg == 13'h000);
      ref_lock_o   <= lock_reg;
    end
  end

  // ****************************************
  // slot mapping
  // ****************************************
  // R3 only 48K and 96K frames exist; quad rate needs 48K frames
  function automatic logic [1:0] grp_shift(input logic f96, input madm_speed_t sp);
    if (f96) begin
      grp_shift = 2'd0;
    end else begin
      case (sp)
        MADM_DOUBLE: grp_shift = 2'd1;
        MADM_QUAD:   grp_shift = 2'd2;
        default:     grp_shift = 2'd0;
      endcase
    end
  endfunction : grp_shift

  logic [1:0] tx_shift;
  logic [5:0] ch_limit;
  logic [1:0] ph_mask;
  logic [5:0] wr_slot;
  logic       wr_ok;

  assign tx_shift = grp_shift(frame_96k_i, speed_mode_i);
  assign ph_mask  = (2'b01 << tx_shift) - 2'b01;
  // R5 R6 R12 R1 channel count per format and speed
  assign ch_limit = frame_96k_i ? 6'h1f : (6'h3f >> tx_shift);
  // R13 R11 later samples into higher slots of the group
  assign wr_slot  = (ch_num_i << tx_shift) | {4'h0, ch_phase_i & ph_mask};
  assign wr_ok    = ch_valid_i && (ch_num_i <= ch_limit) && ((ch_phase_i & ~ph_mask) == 2'b00);

  // ****************************************
  // transmit: frame slots out on link clock
  // ****************************************
  logic [DW-1:0] ram_rdata;
  logic [5:0]    tx_slot_reg;
  logic [5:0]    tx_slot;
  logic          restart_reg;
  logic [6:0]    tx_slots;

  // R9 samples stored untouched
  madm_slot_ram #(.DW(DW), .AW(`MADM_SLOT_W)) u_tx_ram (
    .mclk_i  (mclk_i),
    .we_i    (wr_ok),
    .waddr_i (wr_slot),
    .wdata_i (ch_data_i),
    .raddr_i (tx_slot),
    .rdata_o (ram_rdata)
  );

  // R5 R6 slots per frame
  assign tx_slots = frame_96k_i ? `MADM_SLOTS_96K : `MADM_SLOTS_48K;
  assign tx_slot  = (restart_reg || frame_tick_o) ? 6'h00 : tx_slot_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ch_accept_o <= 1'b0;
    end else begin
      ch_accept_o <= wr_ok;
    end
  end

  // R2 R10 frame restarts on the word clock tick and also wraps after its last slot
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      restart_reg <= 1'b0;
    end else if (link_rise) begin
      restart_reg <= 1'b0;
    end else if (frame_tick_o) begin
      restart_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_slot_reg <= 6'h00;
    end else if (link_rise) begin
      tx_slot_reg <= ({1'b0, tx_slot} + 7'h01 >= tx_slots) ? 6'h00 : tx_slot + 6'h01;
    end
  end

  // R9 slot value sent unchanged
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      link_tx_data_o  <= '0;
      link_tx_valid_o <= 1'b0;
      link_tx_start_o <= 1'b0;
      link_tx_96k_o   <= 1'b0;
    end else begin
      link_tx_valid_o <= link_rise;
      if (link_rise) begin
        link_tx_data_o  <= ram_rdata;
        link_tx_start_o <= (tx_slot == 6'h00);
        link_tx_96k_o   <= frame_96k_i;
      end
    end
  end

  // ****************************************
  // receive: slots back to channel samples
  // ****************************************
  logic [5:0] rx_slot_reg;
  logic [5:0] rx_slot;
  logic       rx_f96_reg;
  logic [1:0] rx_shift;
  logic       rx_f96;

  assign rx_slot  = rx_start ? 6'h00 : rx_slot_reg;
  assign rx_f96   = rx_start ? rx_96k : rx_f96_reg;
  assign rx_shift = grp_shift(rx_f96, speed_mode_i);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_slot_reg <= 6'h00;
      rx_f96_reg  <= 1'b0;
    end else if (link_rise) begin
      rx_slot_reg <= rx_slot + 6'h01;
      rx_f96_reg  <= rx_f96;
    end
  end

  // R13 R9 slot order gives sample order, value kept
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ch_out_valid_o <= 1'b0;
      ch_out_num_o   <= 6'h00;
      ch_out_phase_o <= 2'b00;
      ch_out_data_o  <= '0;
    end else begin
      // R6 96K frame has 32 slots only
      ch_out_valid_o <= link_rise && !(rx_f96 && rx_slot[5]);
      if (link_rise) begin
        ch_out_num_o   <= rx_slot >> rx_shift;
        ch_out_phase_o <= rx_slot[1:0] & ((2'b01 << rx_shift) - 2'b01);
        ch_out_data_o  <= rx_data;
      end
    end
  end

  // R7 96K frame sets double rate by itself; R8 otherwise the setting
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rate_o <= MADM_SINGLE;
    end else if (link_rise && rx_f96) begin
      rate_o <= MADM_DOUBLE;
    end else if (link_rise) begin
      rate_o <= speed_mode_i;
    end
  end
endmodule : madm_sample_mux_mapper
`default_nettype wire

// >>> hw/madm_slot_ram.sv
// slot memory for one outgoing madi frame, write port and asynchronous read
// assumes a single clock; no reset on the array
`timescale 1ns/10ps
`default_nettype none
module madm_slot_ram #(
  parameter int DW    = 24,
  parameter int AW    = 6
) (
  input  wire logic          mclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];
endmodule : madm_slot_ram
`default_nettype wire

// >>> hw/madm_sync.sv
// three-stage synchroniser for pin inputs with rise detection
// assumes inputs are asynchronous to mclk_i
`timescale 1ns/10ps
`default_nettype none
module madm_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          s1_reg[b] <= 1'b0;
          s2_reg[b] <= 1'b0;
          s3_reg[b] <= 1'b0;
          sync_o[b] <= 1'b0;
          rise_o[b] <= 1'b0;
        end else begin
          s1_reg[b] <= async_i[b];
          s2_reg[b] <= s1_reg[b];
          s3_reg[b] <= s2_reg[b];
          // a change counts once stages two and three agree
          if (s2_reg[b] == s3_reg[b]) begin
            sync_o[b] <= s3_reg[b];
            rise_o[b] <= s3_reg[b] & ~sync_o[b];
          end else begin
            rise_o[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule : madm_sync
`default_nettype wire

// >>> tb/madm_remote_model.sv
// remote madi device: sends slots at the link rate
// assumes the bench calls send_frame; link clock stands still between bursts
`timescale 1ns/10ps
`default_nettype none
module madm_remote_model (
  output logic        link_clk_o,
  output logic [23:0] data_o,
  output logic        start_o,
  output logic        f96_o
);
  initial begin
    link_clk_o = 1'h0;
    data_o = 24'h0;
    start_o = 1'h0;
    f96_o = 1'h0;
  end
  // single speed slots in ascending order
  task automatic send_frame(input int n, input logic f96, input logic [23:0] base);
    for (int s = 0; s < n; s++) begin
      data_o = base + 24'(s);
      start_o = (s % 64 == 0);
      f96_o = f96;
      #62.5 link_clk_o = 1'h1;
      #62.5 link_clk_o = 1'h0;
    end
    // released line shows a changed value
    data_o = ~data_o;
    start_o = 1'h0;
  endtask : send_frame
endmodule : madm_remote_model
`default_nettype wire

// >>> tb/madm_sample_mux_mapper_props.sv
// port checker for the madi sample mux mapper
// assumes one mclk_i domain; bound onto the mapper below
`timescale 1ns/10ps
`default_nettype none
module madm_mapper_props (
  input wire logic                  mclk_i,
  input wire logic                  reset_i,
  input wire logic                  frame_96k_i,
  input wire madm_pkg::madm_speed_t speed_mode_i,
  input wire logic                  ch_valid_i,
  input wire logic [5:0]            ch_num_i,
  input wire logic [1:0]            ch_phase_i,
  input wire logic                  ch_accept_o,
  input wire logic                  link_tx_valid_o,
  input wire logic                  ch_out_valid_o,
  input wire madm_pkg::madm_speed_t rate_o,
  input wire logic                  ref_lock_o,
  input wire logic                  frame_tick_o
);
  import madm_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_quad_ch_refused: assert property (
    ch_valid_i && !frame_96k_i && speed_mode_i == MADM_QUAD && ch_num_i > 6'h0f |=> !ch_accept_o)
    else $error("quad write beyond channel 15 accepted");
  a_double_ch_refused: assert property (
    ch_valid_i && !frame_96k_i && speed_mode_i == MADM_DOUBLE && (ch_num_i > 6'h1f || ch_phase_i > 2'h1)
    |=> !ch_accept_o) else $error("double write out of range accepted");
  a_wide_ch_refused: assert property (
    ch_valid_i && frame_96k_i && ch_num_i > 6'h1f |=> !ch_accept_o)
    else $error("wide frame write beyond channel 31 accepted");
  a_single_ch_taken: assert property (
    ch_valid_i && !frame_96k_i && speed_mode_i == MADM_SINGLE && ch_phase_i == 2'h0 |=> ch_accept_o)
    else $error("single rate write not accepted");
  a_rate_from_setting: assert property (
    ch_out_valid_o && rate_o != MADM_DOUBLE |-> rate_o == speed_mode_i)
    else $error("rate differs from speed setting");
  a_rx_tx_aligned: assert property (
    ch_out_valid_o |-> link_tx_valid_o) else $error("receive slot out of step with send slot");
  a_tx_slot_spacing: assert property (
    link_tx_valid_o |=> !link_tx_valid_o [*8]) else $error("send slots too close");
  a_tick_spacing: assert property (
    frame_tick_o |=> !frame_tick_o [*8]) else $error("frame ticks too close");
  c_accept: cover property (ch_accept_o);
  c_wide_rate: cover property (ch_out_valid_o && rate_o == MADM_DOUBLE);
  c_lock: cover property ($rose(ref_lock_o));
endmodule : madm_mapper_props
bind madm_sample_mux_mapper madm_mapper_props i_madm_mapper_props (.mclk_i, .reset_i, .frame_96k_i,
  .speed_mode_i, .ch_valid_i, .ch_num_i, .ch_phase_i, .ch_accept_o, .link_tx_valid_o, .ch_out_valid_o,
  .rate_o, .ref_lock_o, .frame_tick_o);
`default_nettype wire

// >>> tb/madm_sample_mux_mapper_tb_top.sv
// self-checking bench for the madi sample mux mapper
// assumes the remote model on the link and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module madm_sample_mux_mapper_tb_top;
  import madm_pkg::*;
  logic mclk_i, reset_i, frame_96k_i, ref_clk_i, link_clk_i, ch_valid_i, link_rx_start_i, link_rx_96k_i;
  logic link_tx_valid_o, link_tx_start_o, link_tx_96k_o, ch_out_valid_o, ch_accept_o, ref_lock_o;
  logic word_clk_o, frame_tick_o;
  logic [5:0] ch_num_i, ch_out_num_o;
  logic [1:0] ch_phase_i, ch_out_phase_o;
  logic [23:0] ch_data_i, link_rx_data_i, link_tx_data_o, ch_out_data_o;
  madm_speed_t speed_mode_i, rate_o;
  int err_total, total_checks, cyc;
  logic [31:0] rxq[$], txq[$];
  madm_sample_mux_mapper i_madm_sample_mux_mapper (.mclk_i, .reset_i, .frame_96k_i, .speed_mode_i,
    .ref_clk_i, .link_clk_i, .ch_valid_i, .ch_num_i, .ch_phase_i, .ch_data_i, .link_rx_data_i,
    .link_rx_start_i, .link_rx_96k_i, .link_tx_data_o, .link_tx_valid_o, .link_tx_start_o, .link_tx_96k_o,
    .ch_out_valid_o, .ch_out_num_o, .ch_out_phase_o, .ch_out_data_o, .ch_accept_o, .rate_o, .ref_lock_o,
    .word_clk_o, .frame_tick_o);
  madm_remote_model i_madm_remote_model (.link_clk_o(link_clk_i), .data_o(link_rx_data_i),
    .start_o(link_rx_start_i), .f96_o(link_rx_96k_i));
  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end
  // reference of 2083 cycles per period
  // offset keeps reference edges away from the system clock edge
  initial begin
    ref_clk_i = 1'h0;
    #2;
    forever #10415 ref_clk_i = ~ref_clk_i;
  end
  // capture received slots and one sent frame from its start, away from the launching edge
  always @(negedge mclk_i) begin
    if (ch_out_valid_o) rxq.push_back({ch_out_num_o, ch_out_phase_o, ch_out_data_o});
    if (link_tx_valid_o && (txq.size() != 0 || link_tx_start_o) && txq.size() < 64)
      txq.push_back({8'h00, link_tx_data_o});
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input madm_speed_t sp, input logic f96, input logic [5:0] ch, input logic [1:0] ph,
                    input logic exp);
    @(negedge mclk_i);
    speed_mode_i = sp;
    frame_96k_i = f96;
    ch_valid_i = 1'h1;
    ch_num_i = ch;
    ch_phase_i = ph;
    ch_data_i = 24'h5a0000 + {16'h0, ch, ph};
    @(negedge mclk_i);
    chk({31'h0, ch_accept_o}, {31'h0, exp});
    ch_valid_i = 1'h0;
    @(negedge mclk_i);
  endtask : wr
  task automatic s_limits;
    wr(MADM_DOUBLE, 1'h0, 6'h1f, 2'h1, 1'h1);
    wr(MADM_DOUBLE, 1'h0, 6'h20, 2'h0, 1'h0);
    wr(MADM_DOUBLE, 1'h0, 6'h01, 2'h2, 1'h0);
    wr(MADM_SINGLE, 1'h1, 6'h1f, 2'h0, 1'h1);
    wr(MADM_SINGLE, 1'h1, 6'h20, 2'h0, 1'h0);
    wr(MADM_SINGLE, 1'h0, 6'h3f, 2'h0, 1'h1);
    wr(MADM_QUAD, 1'h0, 6'h0f, 2'h3, 1'h1);
    wr(MADM_QUAD, 1'h0, 6'h10, 2'h0, 1'h0);
  endtask : s_limits
  task automatic s_quad_tx;
    for (int i = 0; i < 8; i++) wr(MADM_QUAD, 1'h0, 6'(i >> 2), 2'(i), 1'h1);
    txq.delete();
    i_madm_remote_model.send_frame(200, 1'h0, 24'ha00000);
    repeat (20) @(negedge mclk_i);
    for (int i = 0; i < 8; i++) chk(txq[i], 32'h5a0000 + 32'(i));
    chk({31'h0, link_tx_96k_o}, 32'h0);
  endtask : s_quad_tx
  task automatic s_rx(input madm_speed_t sp, input logic f96, input int sh, input int n);
    @(negedge mclk_i);
    speed_mode_i = sp;
    rxq.delete();
    i_madm_remote_model.send_frame(n, f96, 24'hb00000);
    repeat (20) @(negedge mclk_i);
    chk(32'(rxq.size()), 32'(n));
    chk({30'h0, rate_o}, {30'h0, (f96 ? MADM_DOUBLE : sp)});
    for (int i = 0; i < n; i++)
      chk(rxq[i], {6'(i >> sh), 2'(i & ((1 << sh) - 1)), 24'hb00000 + 24'(i)});
  endtask : s_rx
  task automatic s_lock;
    int cnt;
    int hi;
    for (int i = 0; i < 12000 && ref_lock_o !== 1'h1; i++) @(negedge mclk_i);
    chk({31'h0, ref_lock_o}, 32'h1);
    // pass the free-running tick and the realigning tick, then time a full period
    repeat (2) @(posedge frame_tick_o);
    cnt = 0;
    hi = 0;
    @(negedge mclk_i);
    do begin
      @(negedge mclk_i);
      cnt++;
      hi += int'(word_clk_o === 1'h1);
    end while (frame_tick_o !== 1'h1 && cnt < 3000);
    chk(32'(cnt > 2074 && cnt < 2092), 32'h1);
    chk(32'(hi > 1034 && hi < 1048), 32'h1);
  endtask : s_lock
  initial begin
    reset_i = 1'h1;
    frame_96k_i = 1'h0;
    speed_mode_i = MADM_SINGLE;
    ch_valid_i = 1'h0;
    ch_num_i = 6'h0;
    ch_phase_i = 2'h0;
    ch_data_i = 24'h0;
    repeat (10) @(negedge mclk_i);
    reset_i = 1'h0;
    s_limits();
    s_quad_tx();
    s_rx(MADM_QUAD, 1'h0, 2, 64);
    s_rx(MADM_DOUBLE, 1'h0, 1, 64);
    s_rx(MADM_SINGLE, 1'h1, 0, 32);
    s_lock();
    print_verdict();
  end
endmodule : madm_sample_mux_mapper_tb_top
`default_nettype wire
